//--- fswdt_timer.sv
// fail-safe watchdog timer: 16-bit up counter with prewarning and reset request
// assumes commands and settings are one-cycle strobes from the core on mclk
//
// Behaviour
// - every reset leaves the watchdog counting, no software action needed
// - disable command stops counting, enable command restarts it, any time
// - on overflow prewarning interrupt rises first, reset request follows later
// - counter is sixteen bits and advances once per prescaler tick
// - prescaler divides the system clock by one of two selectable ratios
// - each period starts from a programmable reload value held in a register
// - service loads counter with reload value and clears prescaler together
// - intervals span one fine tick up to full count at coarse ratio
// - power-up settings give about 6.5 ms at a 10 MHz clock
`timescale 1ns/10ps
`default_nettype none
module fswdt_timer import fswdt_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    input wire logic serviceCmd,
    input wire logic watchdogDisableCmd,
    input wire logic watchdogEnableCmd,
    input wire logic configWrite,
    input wire logic [CNT_W-1:0] reloadIn,
    input wire logic coarseSelIn,
    output logic watchdogRunning,
    output logic [CNT_W-1:0] watchdogCount,
    output logic [CNT_W-1:0] watchdogReloadValue,
    output logic coarseSel,
    output logic prewarnIrq,
    output logic resetReq
);
    typedef struct packed {
        fswdt_state_t state;
        logic running;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] reload;
        logic coarse;
        logic [DLY_W-1:0] delay;
        logic prewarn;
        logic resetReq;
    } fswdt_regs_t;

    fswdt_regs_t s;
    fswdt_regs_t next_s;
    logic tick;
    logic overflow;

    // ****************************************
    // prescaler
    // ****************************************
    fswdt_prescaler u_prescaler (
        .mclk(mclk),
        .rst(rst),
        .enable(s.running),
        .clear(serviceCmd),
        .coarseSel(s.coarse),
        .tick(tick)
    );

    // ****************************************
    // counter and overflow sequence
    // ****************************************
    // a tick left over from the cycle the watchdog was stopped is ignored
    assign overflow = s.running && tick && s.count == CNT_ALL_ONES;

    always_comb begin
        next_s = s;
        // enable wins a tie: a watchdog must not be left off by a race
        if (watchdogEnableCmd) begin
            next_s.running = 1'b1;
        end else if (watchdogDisableCmd) begin
            next_s.running = 1'b0;
        end
        if (configWrite) begin
            next_s.reload = reloadIn;
            next_s.coarse = coarseSelIn;
        end
        if (serviceCmd) begin
            next_s.count = s.reload;
        end else if (s.running && tick) begin
            if (overflow) begin
                next_s.count = s.reload;
            end else begin
                next_s.count = s.count + CNT_ONE;
            end
        end
        // the sequence cannot be cancelled once started; only reset ends it
        case (s.state)
            FSWDT_WATCH: begin
                if (overflow) begin
                    next_s.state = FSWDT_PREWARN;
                    next_s.prewarn = 1'b1;
                    next_s.delay = '0;
                end
            end
            FSWDT_PREWARN: begin
                next_s.delay = s.delay + DLY_ONE;
                if (s.delay == PREWARN_LAST) begin
                    next_s.state = FSWDT_RESET;
                    next_s.resetReq = 1'b1;
                end
            end
            FSWDT_RESET: begin
                next_s.resetReq = 1'b1;
            end
            default: begin
                next_s.state = FSWDT_WATCH;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s.state <= FSWDT_WATCH;
            s.running <= 1'b1;
            s.count <= RELOAD_RST;
            s.reload <= RELOAD_RST;
            s.coarse <= COARSE_RST;
            s.delay <= '0;
            s.prewarn <= 1'b0;
            s.resetReq <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign watchdogRunning = s.running;
    assign watchdogCount = s.count;
    assign watchdogReloadValue = s.reload;
    assign coarseSel = s.coarse;
    assign prewarnIrq = s.prewarn;
    assign resetReq = s.resetReq;

    // ****************************************
    // checks
    // ****************************************
    sequence seqQuiet;
        !resetReq [*8];
    endsequence
    sequence seqWarnWait;
        seqQuiet ##1 seqQuiet ##1 resetReq;
    endsequence

    a_runs_after_reset: assert property (@(posedge mclk)
        $past(rst) && !rst |-> watchdogRunning && watchdogCount == RELOAD_RST)
        else $error("watchdog not running after reset");
    a_default_settings: assert property (@(posedge mclk)
        $past(rst) && !rst |-> watchdogReloadValue == RELOAD_RST && coarseSel == COARSE_RST)
        else $error("power-up settings wrong");
    a_disable_stops: assert property (@(posedge mclk) disable iff (rst)
        watchdogDisableCmd && !watchdogEnableCmd |=> !watchdogRunning)
        else $error("disable command ignored");
    a_enable_starts: assert property (@(posedge mclk) disable iff (rst)
        watchdogEnableCmd |=> watchdogRunning)
        else $error("enable command ignored");
    a_prewarn_first: assert property (@(posedge mclk) disable iff (rst)
        $rose(prewarnIrq) |-> seqWarnWait)
        else $error("reset request not 16 cycles after prewarning");
    a_reset_needs_warn: assert property (@(posedge mclk) disable iff (rst)
        resetReq |-> prewarnIrq)
        else $error("reset request without prewarning");
    a_count_step: assert property (@(posedge mclk) disable iff (rst)
        watchdogRunning && tick && !serviceCmd && watchdogCount != CNT_ALL_ONES
        |=> watchdogCount == $past(watchdogCount) + CNT_ONE)
        else $error("counter did not advance on tick");
    a_hold_no_tick: assert property (@(posedge mclk) disable iff (rst)
        !serviceCmd && !(watchdogRunning && tick) |=> $stable(watchdogCount))
        else $error("counter moved without a tick");
    a_service_load: assert property (@(posedge mclk) disable iff (rst)
        serviceCmd |=> watchdogCount == $past(watchdogReloadValue))
        else $error("service did not load reload value");
    a_config_load: assert property (@(posedge mclk) disable iff (rst)
        configWrite |=> watchdogReloadValue == $past(reloadIn) && coarseSel == $past(coarseSelIn))
        else $error("settings not stored");
    a_wrap_reload: assert property (@(posedge mclk) disable iff (rst)
        overflow && !serviceCmd && s.state == FSWDT_WATCH
        |=> watchdogCount == $past(watchdogReloadValue) && prewarnIrq)
        else $error("overflow did not reload and warn");

    // ****************************************
    // checks on the overflow sequence and held state
    // ****************************************
    // both requests are sticky: once warned, software cannot talk its way out
    a_warn_sticky: assert property (@(posedge mclk) disable iff (rst)
        prewarnIrq |=> prewarnIrq)
        else $error("prewarning dropped without reset");
    a_reset_sticky: assert property (@(posedge mclk) disable iff (rst)
        resetReq |=> resetReq)
        else $error("reset request dropped without reset");
    a_warn_cause: assert property (@(posedge mclk) disable iff (rst)
        $rose(prewarnIrq) |-> $past(overflow))
        else $error("prewarning without overflow");
    a_reset_gap: assert property (@(posedge mclk) disable iff (rst)
        $rose(resetReq) |-> $past(prewarnIrq, 16) && !$past(prewarnIrq, 17))
        else $error("reset request not 16 cycles after prewarning");
    a_watch_quiet: assert property (@(posedge mclk) disable iff (rst)
        s.state == FSWDT_WATCH |-> !prewarnIrq && !resetReq)
        else $error("request raised while still watching");
    a_reset_state: assert property (@(posedge mclk) disable iff (rst)
        s.state == FSWDT_RESET |-> resetReq && prewarnIrq)
        else $error("reset state without both requests");
    a_delay_range: assert property (@(posedge mclk) disable iff (rst)
        s.state == FSWDT_PREWARN |-> s.delay <= PREWARN_LAST)
        else $error("prewarning delay ran past its end");
    a_state_onehot: assert property (@(posedge mclk) disable iff (rst)
        $onehot(s.state))
        else $error("sequence state not one-hot");
    a_stopped_hold: assert property (@(posedge mclk) disable iff (rst)
        !watchdogRunning && !serviceCmd |=> $stable(watchdogCount))
        else $error("stopped counter moved");
    a_cmd_hold: assert property (@(posedge mclk) disable iff (rst)
        !watchdogEnableCmd && !watchdogDisableCmd |=> $stable(watchdogRunning))
        else $error("run state changed without a command");
    a_config_hold: assert property (@(posedge mclk) disable iff (rst)
        !configWrite |=> $stable(watchdogReloadValue) && $stable(coarseSel))
        else $error("settings changed without a write");
    a_service_clear: assert property (@(posedge mclk) disable iff (rst)
        serviceCmd |=> !tick)
        else $error("prescaler not cleared by service");
    a_tick_spacing: assert property (@(posedge mclk) disable iff (rst)
        tick |=> !tick [*8])
        else $error("prescaler ticks too close together");
    a_wrap_any: assert property (@(posedge mclk) disable iff (rst)
        overflow && !serviceCmd |=> watchdogCount == $past(watchdogReloadValue))
        else $error("overflow did not reload the counter");
endmodule // fswdt_timer
`default_nettype wire

//--- fswdt_pkg.sv
// fail-safe watchdog package: widths, reset values, prescaler ratios and timing counts
// assumes one 100 MHz system clock shared by every user of these constants
package fswdt_pkg;
    // ****************************************
    // counter and prescaler geometry
    // ****************************************
    localparam int CNT_W = 16;
    localparam int PRE_W = 14;
    localparam logic [PRE_W-1:0] PRE_FINE_LAST = 14'h00FF;
    localparam logic [PRE_W-1:0] PRE_COARSE_LAST = 14'h3FFF;
    localparam logic [CNT_W-1:0] CNT_ALL_ONES = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    // ****************************************
    // power-up settings
    // ****************************************
    // fine prescaler and 256 ticks give 65536 clocks, about 6.5 ms at 10 MHz
    localparam logic [CNT_W-1:0] RELOAD_RST = 16'hFF00;
    localparam logic COARSE_RST = 1'b0;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int PREWARN_TIME_NS = 160;
    // least time from prewarning to reset request, rounded up to whole cycles
    localparam int PREWARN_CYCLES = (PREWARN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_W = 5;
    localparam logic [DLY_W-1:0] PREWARN_LAST = DLY_W'(PREWARN_CYCLES - 1);
    localparam logic [DLY_W-1:0] DLY_ONE = 5'h01;

    typedef enum logic [2:0] {
        FSWDT_WATCH = 3'h1,
        FSWDT_PREWARN = 3'h2,
        FSWDT_RESET = 3'h4
    } fswdt_state_t;
endpackage

//--- fswdt_prescaler.sv
// fail-safe watchdog prescaler: divides the system clock by 256 or 16384
// assumes enable, clear and select come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module fswdt_prescaler import fswdt_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    input wire logic enable,
    input wire logic clear,
    input wire logic coarseSel,
    output logic tick
);
    typedef struct packed {
        logic [PRE_W-1:0] count;
        logic tick;
    } fswdt_pre_t;

    fswdt_pre_t s;
    fswdt_pre_t next_s;
    logic [PRE_W-1:0] lastCount;

    assign lastCount = coarseSel ? PRE_COARSE_LAST : PRE_FINE_LAST;

    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (clear) begin
            next_s.count = '0;
        end else if (enable) begin
            if (s.count >= lastCount) begin
                next_s.count = '0;
                next_s.tick = 1'b1;
            end else begin
                next_s.count = s.count + 14'h0001;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

    // ****************************************
    // checks
    // ****************************************
    a_tick_at_terminal: assert property (@(posedge mclk) disable iff (rst)
        enable && !clear && s.count == lastCount |=> tick)
        else $error("prescaler missed its terminal count");
    a_tick_only_terminal: assert property (@(posedge mclk) disable iff (rst)
        tick |-> s.count == '0 && !$past(clear) && $past(enable))
        else $error("prescaler ticked off its terminal count");
endmodule // fswdt_prescaler
`default_nettype wire

//--- fswdt_core_model.sv
// core model: service strobes on request, or on its own steady cadence
// assumes the bench raises requests just after mclk rising edges
`timescale 1ns/10ps
`default_nettype none
module fswdt_core_model #(
    parameter int SVC_PERIOD = 1000
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic svcReq,
    input wire logic autoSvc,
    output logic serviceCmd
);
    int gap;
    logic autoPulse;
    // the cadence must stay well inside the interval the bench programs while autoSvc is on
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gap <= 0;
            autoPulse <= 1'b0;
        end else begin
            gap <= (gap == SVC_PERIOD - 1) ? 0 : gap + 1;
            autoPulse <= autoSvc && (gap == SVC_PERIOD - 1);
        end
    end
    assign serviceCmd = svcReq | autoPulse;
endmodule // fswdt_core_model
`default_nettype wire

//--- fail_safe_watchdog_timer_bench.sv
// watchdog bench: reset defaults, reload, prescaler, enable and overflow sequence
// assumes the timer and the core model share one 100 MHz clock
`timescale 1ns/10ps
`default_nettype none
module fail_safe_watchdog_timer_bench import fswdt_pkg::*;;
    logic mclk, rst, svcReq, autoSvc, serviceCmd, watchdogDisableCmd, watchdogEnableCmd;
    logic configWrite, coarseSelIn, watchdogRunning, coarseSel, prewarnIrq, resetReq;
    logic [CNT_W-1:0] reloadIn, watchdogCount, watchdogReloadValue, r, c;
    int n_mismatch, tests_run, cycles, seed, n, i;

    fswdt_core_model coreU (.mclk(mclk), .rst(rst), .svcReq(svcReq), .autoSvc(autoSvc),
        .serviceCmd(serviceCmd));
    fswdt_timer dut_u (.mclk(mclk), .rst(rst), .serviceCmd(serviceCmd),
        .watchdogDisableCmd(watchdogDisableCmd), .watchdogEnableCmd(watchdogEnableCmd),
        .configWrite(configWrite), .reloadIn(reloadIn), .coarseSelIn(coarseSelIn),
        .watchdogRunning(watchdogRunning), .watchdogCount(watchdogCount),
        .watchdogReloadValue(watchdogReloadValue), .coarseSel(coarseSel),
        .prewarnIrq(prewarnIrq), .resetReq(resetReq));

    always #5 mclk = ~mclk;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [CNT_W-1:0] expNext(input logic [CNT_W-1:0] v, rel);
        return (v == CNT_ALL_ONES) ? rel : v + CNT_ONE;
    endfunction
    task automatic check(input string what, input logic [CNT_W-1:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic edges(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    // strobes are high for exactly the one edge at which the timer takes them
    task automatic strobe(input logic s, d, e, w, input logic [CNT_W-1:0] v, input logic k);
        @(posedge mclk);
        svcReq <= s;
        watchdogDisableCmd <= d;
        watchdogEnableCmd <= e;
        configWrite <= w;
        reloadIn <= v;
        coarseSelIn <= k;
        @(posedge mclk);
        svcReq <= 1'b0;
        watchdogDisableCmd <= 1'b0;
        watchdogEnableCmd <= 1'b0;
        configWrite <= 1'b0;
        #1;
    endtask
    task automatic doReset();
        rst <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        #1;
    endtask
    task automatic end_sim();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // the full run needs about 89000 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 99000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        seed = 87594;
        mclk = 1'b0;
        rst = 1'b1;
        {svcReq, autoSvc, watchdogDisableCmd, watchdogEnableCmd, configWrite, coarseSelIn} = '0;
        reloadIn = '0;
        doReset();
        check("running", CNT_ONE, CNT_W'(watchdogRunning));
        check("count", RELOAD_RST, watchdogCount);
        check("reload", RELOAD_RST, watchdogReloadValue);
        check("coarse", CNT_W'(COARSE_RST), CNT_W'(coarseSel));
        edges(65400);
        check("early prewarn", '0, CNT_W'(prewarnIrq));
        for (n = 0; n < 300 && prewarnIrq !== 1'b1; n++) begin
            edges(1);
        end
        check("prewarn", CNT_ONE, CNT_W'(prewarnIrq));
        check("reset early", '0, CNT_W'(resetReq));
        for (n = 0; n < 40 && resetReq !== 1'b1; n++) begin
            edges(1);
        end
        check("prewarn gap", CNT_W'(PREWARN_CYCLES), CNT_W'(n));
        doReset();
        // first pass is the shortest interval: one fine tick, then overflow
        for (i = 0; i < 4; i++) begin
            r = (i == 0) ? CNT_ALL_ONES : CNT_W'($random(seed));
            strobe(1'b0, 1'b0, 1'b0, 1'b1, r, 1'b0);
            check("reload", r, watchdogReloadValue);
            strobe(1'b1, 1'b0, 1'b0, 1'b0, r, 1'b0);
            check("serviced", r, watchdogCount);
            edges(256);
            check("before tick", r, watchdogCount);
            edges(1);
            check("after tick", expNext(r, r), watchdogCount);
        end
        check("wrap prewarn", CNT_ONE, CNT_W'(prewarnIrq));
        strobe(1'b0, 1'b1, 1'b0, 1'b0, r, 1'b0);
        check("stopped", '0, CNT_W'(watchdogRunning));
        c = watchdogCount;
        edges(600);
        check("held", c, watchdogCount);
        strobe(1'b1, 1'b1, 1'b1, 1'b0, r, 1'b0);
        check("restarted", CNT_ONE, CNT_W'(watchdogRunning));
        edges(257);
        check("moving", expNext(r, r), watchdogCount);
        strobe(1'b0, 1'b0, 1'b0, 1'b1, r, 1'b1);
        check("coarse set", CNT_ONE, CNT_W'(coarseSel));
        strobe(1'b1, 1'b0, 1'b0, 1'b0, r, 1'b1);
        edges(16384);
        check("coarse before", r, watchdogCount);
        edges(1);
        check("coarse after", expNext(r, r), watchdogCount);
        doReset();
        // short reload: taken up at the core's first service, after which its cadence keeps it from overflow
        strobe(1'b0, 1'b0, 1'b1, 1'b1, 16'hFFF0, 1'b0);
        check("kept reload", 16'hFFF0, watchdogReloadValue);
        @(posedge mclk);
        autoSvc <= 1'b1;
        edges(5000);
        check("kept prewarn", '0, CNT_W'(prewarnIrq));
        check("kept reset", '0, CNT_W'(resetReq));
        end_sim();
    end
endmodule // fail_safe_watchdog_timer_bench
`default_nettype wire
